// ### pkg/pcf_pkg.sv
package pcf_pkg;

  localparam int unsigned NUM_EVT = 4;
  localparam int unsigned NUM_CNT = 5;
  // internal vectors: index 4 is the cycle counter, 3:0 the event counters
  localparam int unsigned CYC_IDX = 4;
  localparam int unsigned REG_CYC_BIT = 31;
  localparam int unsigned REG_EVT_MSB = 3;

  localparam logic [3:0] CRN_MONITOR = 4'h9;
  localparam logic [3:0] CRM_MONITOR = 4'hc;
  localparam logic [2:0] OPC1_MONITOR = 3'h0;
  localparam logic [2:0] SEL_ENABLE_SET = 3'h1;
  localparam logic [2:0] SEL_ENABLE_CLEAR = 3'h2;
  localparam logic [2:0] SEL_OVERFLOW = 3'h3;
  localparam logic [2:0] SEL_SW_INCREMENT = 3'h4;

  localparam logic [7:0] EVT_SW_INCREMENT = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [NUM_CNT-1:0] ENABLE_RESET = 5'h00;
  localparam logic [NUM_CNT-1:0] FLAG_RESET = 5'h00;

  typedef logic [NUM_EVT-1:0][7:0] pcf_evt_code_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } pcf_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } pcf_cp_req_s;

  typedef struct packed {
    logic done;
    logic undef;
    logic [31:0] rdata;
  } pcf_cp_rsp_s;

endpackage

// ### design/pcf_sticky_bank.sv
`timescale 1ns/1ps
module pcf_sticky_bank
  import pcf_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_CNT,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  output logic [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // set beats clear so an event in the clearing cycle is kept
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          q[i] <= INIT[i];
        end else if (set_vec[i]) begin
          q[i] <= 1'b1;
        end else if (clr_vec[i]) begin
          q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ### design/pcf_perf_flags.sv
`timescale 1ns/1ps
module pcf_perf_flags
  import pcf_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire pcf_cp_req_s CP_REQ,
  output logic CP_READY,
  output pcf_cp_rsp_s CP_RSP,
  input wire logic USER_ACCESS_EN,
  input wire logic GLOBAL_EN,
  input wire pcf_evt_code_t EVENT_CODE,
  input wire logic [NUM_CNT-1:0] OVERFLOW_PULSE,
  output logic [NUM_CNT-1:0] COUNT_ENABLE,
  output logic [NUM_CNT-1:0] ENABLE_STATE,
  output logic [NUM_CNT-1:0] OVERFLOW_FLAGS,
  output logic [NUM_EVT-1:0] SW_INCREMENT_PULSE
);

  pcf_state_e state;
  pcf_state_e next_state;

  logic [NUM_CNT-1:0] enable_state;
  logic [NUM_CNT-1:0] overflow_flag;
  logic [NUM_CNT-1:0] enable_set_vec;
  logic [NUM_CNT-1:0] enable_clr_vec;
  logic [NUM_CNT-1:0] flag_clr_vec;
  logic [NUM_CNT-1:0] wdata_cnt;
  logic [NUM_EVT-1:0] swinc_ok;
  logic [NUM_EVT-1:0] next_swinc;

  logic take;
  logic is_monitor;
  logic hit_set;
  logic hit_clear;
  logic hit_flag;
  logic hit_swinc;
  logic hit_any;
  logic permitted;
  logic do_write;
  logic [31:0] next_rdata;

  // packs a 5-bit internal vector into the register's word layout
  function automatic logic [31:0] to_word(input logic [NUM_CNT-1:0] v);
    logic [31:0] w;
    w = READ_ZERO;
    w[REG_CYC_BIT] = v[CYC_IDX];
    w[REG_EVT_MSB:0] = v[NUM_EVT-1:0];
    return w;
  endfunction

  // unpacks a written word; reserved bits 30:4 are dropped
  function automatic logic [NUM_CNT-1:0] from_word(input logic [31:0] w);
    logic [NUM_CNT-1:0] v;
    v = ENABLE_RESET;
    v[CYC_IDX] = w[REG_CYC_BIT];
    v[NUM_EVT-1:0] = w[REG_EVT_MSB:0];
    return v;
  endfunction

  // one decoder serves both security states, there is no banked copy
  always_comb begin
    is_monitor = (CP_REQ.crn == CRN_MONITOR) && (CP_REQ.crm == CRM_MONITOR) &&
                 (CP_REQ.opc1 == OPC1_MONITOR);
    hit_set = is_monitor && (CP_REQ.opc2 == SEL_ENABLE_SET);
    hit_clear = is_monitor && (CP_REQ.opc2 == SEL_ENABLE_CLEAR);
    hit_flag = is_monitor && (CP_REQ.opc2 == SEL_OVERFLOW);
    hit_swinc = is_monitor && (CP_REQ.opc2 == SEL_SW_INCREMENT);
    hit_any = hit_set || hit_clear || hit_flag || hit_swinc;
  end

  // requests that miss this block are left for other coprocessor logic
  assign CP_READY = (state == ST_IDLE);
  assign take = CP_REQ.valid && CP_READY && hit_any;
  assign permitted = CP_REQ.priv || USER_ACCESS_EN;
  assign do_write = take && CP_REQ.write && permitted;
  assign wdata_cnt = from_word(CP_REQ.wdata);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // enable-set and enable-clear act on one shared state
  always_comb begin
    enable_set_vec = ENABLE_RESET;
    enable_clr_vec = ENABLE_RESET;
    if (do_write && hit_set) begin
      enable_set_vec = wdata_cnt;
    end
    if (do_write && hit_clear) begin
      enable_clr_vec = wdata_cnt;
    end
  end

  pcf_sticky_bank #(
    .WIDTH(NUM_CNT),
    .INIT(ENABLE_RESET)
  ) u_enable (
    .clk(CLOCK),
    .rst(SYS_RST),
    .set_vec(enable_set_vec),
    .clr_vec(enable_clr_vec),
    .q(enable_state)
  );

  // a wrap pulse arriving with a clearing write leaves the flag set
  always_comb begin
    flag_clr_vec = FLAG_RESET;
    if (do_write && hit_flag) begin
      flag_clr_vec = wdata_cnt;
    end
  end

  pcf_sticky_bank #(
    .WIDTH(NUM_CNT),
    .INIT(FLAG_RESET)
  ) u_overflow (
    .clk(CLOCK),
    .rst(SYS_RST),
    .set_vec(OVERFLOW_PULSE),
    .clr_vec(flag_clr_vec),
    .q(overflow_flag)
  );

  // stored enables survive a global stop, only their effect is masked
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      COUNT_ENABLE <= ENABLE_RESET;
    end else begin
      COUNT_ENABLE <= GLOBAL_EN ? enable_state : ENABLE_RESET;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ENABLE_STATE <= ENABLE_RESET;
      OVERFLOW_FLAGS <= FLAG_RESET;
    end else begin
      ENABLE_STATE <= enable_state;
      OVERFLOW_FLAGS <= overflow_flag;
    end
  end

  // a stopped counter takes no software step either
  genvar i;
  generate
    for (i = 0; i < NUM_EVT; i++) begin : g_swinc
      assign swinc_ok[i] = (EVENT_CODE[i] == EVT_SW_INCREMENT) &&
                           GLOBAL_EN && enable_state[i];
    end
  endgenerate

  always_comb begin
    next_swinc = ENABLE_RESET[NUM_EVT-1:0];
    if (do_write && hit_swinc) begin
      next_swinc = CP_REQ.wdata[REG_EVT_MSB:0] & swinc_ok;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SW_INCREMENT_PULSE <= ENABLE_RESET[NUM_EVT-1:0];
    end else begin
      SW_INCREMENT_PULSE <= next_swinc;
    end
  end

  // read data is sampled at the take edge so it shows pre-write state
  always_comb begin
    next_rdata = READ_ZERO;
    if (!CP_REQ.write && permitted) begin
      if (hit_set || hit_clear) begin
        next_rdata = to_word(enable_state);
      end else if (hit_flag) begin
        next_rdata = to_word(overflow_flag);
      end else if (hit_swinc) begin
        next_rdata = READ_ZERO;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CP_RSP <= '0;
    end else begin
      CP_RSP.done <= take;
      CP_RSP.undef <= take && !permitted;
      CP_RSP.rdata <= take ? next_rdata : READ_ZERO;
    end
  end

endmodule

// ### tb/pcf_perf_flags_props.sv
`timescale 1ns/1ps
module pcf_perf_flags_props
  import pcf_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire pcf_cp_req_s CP_REQ,
  input wire logic CP_READY,
  input wire pcf_cp_rsp_s CP_RSP,
  input wire logic USER_ACCESS_EN,
  input wire logic GLOBAL_EN,
  input wire pcf_evt_code_t EVENT_CODE,
  input wire logic [NUM_CNT-1:0] OVERFLOW_PULSE,
  input wire logic [NUM_CNT-1:0] COUNT_ENABLE,
  input wire logic [NUM_CNT-1:0] ENABLE_STATE,
  input wire logic [NUM_CNT-1:0] OVERFLOW_FLAGS,
  input wire logic [NUM_EVT-1:0] SW_INCREMENT_PULSE
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  logic tk, ok;
  logic [NUM_CNT-1:0] m;
  logic [NUM_EVT-1:0] z;
  // bench core never varies opc1 or crm
  assign tk = CP_REQ.valid && CP_READY && CP_REQ.crn == CRN_MONITOR && CP_REQ.opc2 inside {[1:4]};
  assign ok = tk && CP_REQ.write && (CP_REQ.priv || USER_ACCESS_EN);
  assign m = {CP_REQ.wdata[REG_CYC_BIT], CP_REQ.wdata[REG_EVT_MSB:0]};
  always_comb for (int i = 0; i < NUM_EVT; i++) z[i] = EVENT_CODE[i] == EVT_SW_INCREMENT;
  property p_ans; tk |=> CP_RSP.done && !CP_READY; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_und; tk && !CP_REQ.priv && !USER_ACCESS_EN |=> CP_RSP.undef && CP_RSP.rdata == '0; endproperty
  a_und: assert property (p_und) else $error("not refused");
  property p_inz; tk && CP_REQ.opc2 == SEL_SW_INCREMENT |=> CP_RSP.rdata == READ_ZERO; endproperty
  a_inz: assert property (p_inz) else $error("nonzero read");
  property p_enc; ok && CP_REQ.opc2 == SEL_ENABLE_CLEAR |-> ##2 (ENABLE_STATE & $past(m, 2)) == '0; endproperty
  a_enc: assert property (p_enc) else $error("enable kept");
  property p_flc; ok && CP_REQ.opc2 == SEL_OVERFLOW && OVERFLOW_PULSE == '0 ##1 OVERFLOW_PULSE == '0
    |=> (OVERFLOW_FLAGS & $past(m, 2)) == '0; endproperty
  a_flc: assert property (p_flc) else $error("flag kept");
  property p_stk; OVERFLOW_PULSE != '0 ##1 !tk
    |=> (OVERFLOW_FLAGS & $past(OVERFLOW_PULSE, 2)) == $past(OVERFLOW_PULSE, 2); endproperty
  a_stk: assert property (p_stk) else $error("flag lost");
  property p_off; !GLOBAL_EN [*2] |-> COUNT_ENABLE == '0; endproperty
  a_off: assert property (p_off) else $error("counting while off");
  property p_inc; ok && CP_REQ.opc2 == SEL_SW_INCREMENT
    |=> SW_INCREMENT_PULSE == $past(CP_REQ.wdata[3:0] & z & ENABLE_STATE[3:0] & {4{GLOBAL_EN}}); endproperty
  a_inc: assert property (p_inc) else $error("wrong step");
endmodule
bind pcf_perf_flags pcf_perf_flags_props u_props(.*);

// ### tb/pcf_core_model.sv
`timescale 1ns/1ps
module pcf_core_model
  import pcf_pkg::*;
(
  input wire logic CLOCK,
  input wire logic CP_READY,
  input wire pcf_cp_rsp_s CP_RSP,
  output pcf_cp_req_s CP_REQ
);
  initial CP_REQ = '0;
  task automatic xfer(input logic w, p, input logic [3:0] crn, input logic [2:0] sel, input logic [31:0] d,
    output pcf_cp_rsp_s r);
    pcf_cp_req_s q;
    q = {1'b1, w, p, OPC1_MONITOR, crn, CRM_MONITOR, sel, d};
    @(negedge CLOCK);
    CP_REQ <= q;
    while (CP_READY !== 1'b1) @(negedge CLOCK);
    @(negedge CLOCK);
    r = CP_RSP;
    // released lines show garbage, not the old request
    CP_REQ <= {1'b0, ~q[$bits(q)-2:0]};
  endtask
endmodule

// ### tb/tb_pcf_perf_flags.sv
`timescale 1ns/1ps
module tb_pcf_perf_flags
  import pcf_pkg::*;
;
  logic CLOCK = 0, SYS_RST = 1, USER_ACCESS_EN = 1, GLOBAL_EN = 1, CP_READY;
  logic [NUM_CNT-1:0] OVERFLOW_PULSE = '0, COUNT_ENABLE, ENABLE_STATE, OVERFLOW_FLAGS;
  logic [NUM_EVT-1:0] SW_INCREMENT_PULSE;
  pcf_evt_code_t EVENT_CODE = '0;
  pcf_cp_req_s CP_REQ;
  pcf_cp_rsp_s CP_RSP, r;
  int n_errors = 0, tests_run = 0;
  localparam logic [33:0] WOK = 34'h2_0000_0000;
  pcf_perf_flags dut(.*);
  pcf_core_model core(.*);
  initial forever #25 CLOCK = ~CLOCK;
  task automatic check(input string nm, input logic [33:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic io(input logic w, p, input logic [2:0] sel, input logic [31:0] d, input logic [33:0] exp);
    core.xfer(w, p, CRN_MONITOR, sel, d, r);
    check("rsp", {r.done, r.undef, r.rdata}, exp);
  endtask
  task automatic t_en;
    check("rst", {ENABLE_STATE, OVERFLOW_FLAGS}, '0);
    io(1, 1, SEL_ENABLE_SET, 32'hffff_ffff, WOK);
    io(0, 1, SEL_ENABLE_CLEAR, 32'h0, 34'h2_8000_000f);
    io(1, 1, SEL_ENABLE_CLEAR, 32'h7fff_fff5, WOK);
    io(0, 1, SEL_ENABLE_CLEAR, 32'h0, 34'h2_8000_000a);
    check("cen", COUNT_ENABLE, 5'h1a);
    GLOBAL_EN = 0;
    repeat (2) @(negedge CLOCK);
    check("cen", COUNT_ENABLE, 5'h00);
    io(0, 1, SEL_ENABLE_CLEAR, 32'h0, 34'h2_8000_000a);
    GLOBAL_EN = 1;
  endtask
  task automatic t_fl;
    OVERFLOW_PULSE = 5'h1f;
    @(negedge CLOCK) OVERFLOW_PULSE = 5'h00;
    io(0, 1, SEL_OVERFLOW, 32'h0, 34'h2_8000_000f);
    io(1, 1, SEL_OVERFLOW, 32'h7fff_fff5, WOK);
    io(0, 1, SEL_OVERFLOW, 32'h0, 34'h2_8000_000a);
    check("flg", OVERFLOW_FLAGS, 5'h1a);
  endtask
  task automatic t_inc;
    EVENT_CODE = {8'h00, 8'h00, 8'h11, 8'h00};
    io(1, 1, SEL_SW_INCREMENT, 32'hffff_ffff, WOK);
    check("inc", SW_INCREMENT_PULSE, 4'h8);
    EVENT_CODE = '0;
    io(1, 0, SEL_SW_INCREMENT, 32'h0000_0002, WOK);
    check("inc", SW_INCREMENT_PULSE, 4'h2);
    io(0, 0, SEL_SW_INCREMENT, 32'h0, WOK);
  endtask
  task automatic t_acc;
    USER_ACCESS_EN = 0;
    io(1, 0, SEL_ENABLE_CLEAR, 32'hffff_ffff, 34'h3_0000_0000);
    io(0, 1, SEL_ENABLE_CLEAR, 32'h0, 34'h2_8000_000a);
    core.xfer(0, 1, 4'h8, SEL_ENABLE_CLEAR, 32'h0, r);
    check("crn", r.done, 1'b0);
    USER_ACCESS_EN = 1;
  endtask
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge CLOCK);
    SYS_RST = 0;
    t_en;
    t_fl;
    t_inc;
    t_acc;
    final_report;
  end
  initial begin
    repeat (400) @(posedge CLOCK);
    n_errors++;
    final_report;
  end
endmodule
